//--- shared/urx_defines.svh
// constants for the receive side of the serial port: status bit positions, ticks per bit for each clock factor,
// buffer sizing. assumes inclusion by bare name.
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH
// receive/transmit status bit positions
`define URX_RT_RX_READY 0
`define URX_RT_TX_EMPTY 1
`define URX_RT_PARITY 2
`define URX_RT_FRAMING 3
`define URX_RT_OVERRUN 4
`define URX_RT_DATA_SET_CHANGE_FLAG 7
// modem status bit positions
`define URX_MS_BRK_CHG 3
`define URX_MS_BRK 7
// parity modes
`define URX_PAR_ODD 2'h0
`define URX_PAR_EVEN 2'h1
`define URX_PAR_MARK 2'h2
// clock factor ticks per bit
`define URX_BIT_1X 7'h01
`define URX_BIT_16X 7'h10
`define URX_BIT_32X 7'h20
`define URX_BIT_64X 7'h40
// buffering and reset values
`define URX_FIFO_DEPTH 32
`define URX_ENTRY_W 11
`define URX_DATA_RST 8'h00
`endif

//--- shared/urx_pkg.sv
// types shared by the receiver and its buffer.
// assumes nothing of its surroundings.
package urx_pkg;
  typedef enum logic [2:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_PARITY,
    URX_STOP,
    URX_BRK_WAIT
  } urx_state_e;
  typedef logic [7:0] urx_byte_t;
endpackage

//--- testbench/urx_line_model.sv
// far-end serial transmitter: start, data lsb first, optional parity, stop.
// assumes each task is entered just after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module urx_line_model #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic clk,
  // line side
  output logic line,
  output logic clk_pin
);
  initial begin
    line = 1'b1;
    clk_pin = 1'b0;
  end

  // one bit cell; the 1x bit clock falls at the cell centre, still between frames
  task automatic bit_out(input logic v, input bit x1);
    int i;
    for (i = 0; i < BIT_CYC; i++) begin
      if (i == 0) line = v;
      clk_pin = x1 && i >= BIT_CYC / 4 && i < BIT_CYC / 2;
      @(posedge clk);
      #1;
    end
  endtask

  // hold the line for a while: idle mark, glitch or break
  task automatic level(input logic v, input int cyc);
    line = v;
    repeat (cyc) @(posedge clk);
    #1;
  endtask

  task automatic send_char(input logic [7:0] d, input int nbits, input bit par_en,
      input logic par_val, input logic stop_val, input bit x1);
    int i;
    // 1x receiver needs one clocked mark before the start edge
    if (x1) bit_out(1'b1, 1'b1);
    bit_out(1'b0, x1);
    for (i = 0; i < nbits; i++) bit_out(d[i], x1);
    if (par_en) bit_out(par_val, x1);
    bit_out(stop_val, x1);
  endtask
endmodule
`default_nettype wire

//--- testbench/urx_receiver_tb.sv
// self-checking bench: a line model sends frames, a watcher reads and checks
// every character the receiver delivers. assumes the line model compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "urx_defines.svh"
module urx_receiver_tb
  import urx_pkg::*;
;
  logic REF_CLK = 1'b0, RSTN, MASTER_RESET_PIN, POWER_DOWN_PIN, RXD, RX_CLOCK_PIN, TX_CLOCK_PIN;
  logic DCD_N, CTS_N, DSR_N, TXD, DTR_N, RTS_N, RX_ENABLE_BIT, CARRIER_AUTO_EN, PARITY_EN;
  logic [1:0] CHAR_LEN, PARITY_MODE, CLOCK_FACTOR;
  logic RX_CLOCK_INTERNAL, BAUD_TICK = 1'b0, LOCAL_LOOP, REMOTE_LOOP, DTR_CMD, RTS_CMD;
  logic [7:0] RT_MASK, MODEM_MASK, RT_STATUS, MODEM_STATUS;
  logic RHR_READ = 1'b0, RT_STATUS_READ, MODEM_STATUS_READ, COMBINED_IRQ_N, TX_SERIAL;
  logic TX_BUFFER_EMPTY_FLAG = 1'b1, CPU_TX_WRITE, TX_LOAD, TX_FORCE_EN, TX_CLOCK_OUT;
  logic CTS_N_INT, DSR_ACTIVE, line, line_clk, junk = 1'b0, hold_reads, fast_tick = 1'b0;
  urx_byte_t RX_DATA, CPU_TX_DATA, TX_DATA, d, p;
  logic [31:0] lfsr = 32'hB441;
  logic [9:0] notes[$];
  int miscompares, compares, i, pm, bad;

  // in local loop the outside line carries junk that must be ignored
  assign RXD = LOCAL_LOOP ? junk : line;
  assign TX_SERIAL = LOCAL_LOOP ? line : 1'b1;
  assign RX_CLOCK_PIN = line_clk;

  urx_receiver #(.FIFO_DEPTH(`URX_FIFO_DEPTH)) urx_receiver_i (.REF_CLK, .RSTN,
    .MASTER_RESET_PIN, .POWER_DOWN_PIN, .RXD, .RX_CLOCK_PIN, .TX_CLOCK_PIN, .DCD_N, .CTS_N,
    .DSR_N, .TXD, .DTR_N, .RTS_N, .RX_ENABLE_BIT, .CARRIER_AUTO_EN, .CHAR_LEN, .PARITY_EN,
    .PARITY_MODE, .CLOCK_FACTOR, .RX_CLOCK_INTERNAL, .BAUD_TICK, .LOCAL_LOOP, .REMOTE_LOOP,
    .DTR_CMD, .RTS_CMD, .RT_MASK, .MODEM_MASK, .RHR_READ, .RT_STATUS_READ,
    .MODEM_STATUS_READ, .RX_DATA, .RT_STATUS, .MODEM_STATUS, .COMBINED_IRQ_N, .TX_SERIAL,
    .TX_BUFFER_EMPTY_FLAG, .CPU_TX_WRITE, .CPU_TX_DATA, .TX_LOAD, .TX_DATA, .TX_FORCE_EN,
    .TX_CLOCK_OUT, .CTS_N_INT, .DSR_ACTIVE);

  urx_line_model #(.BIT_CYC(32)) urx_line_model_i (.clk(REF_CLK), .line(line),
    .clk_pin(line_clk));

  always #2 REF_CLK = ~REF_CLK;

  // tick every second cycle (16x) or every cycle when fast (32x) over a 32-cycle bit
  always @(posedge REF_CLK) begin
    #1;
    BAUD_TICK = fast_tick | ~BAUD_TICK;
    junk = ~junk;
  end

  // transmitter stand-in: a load keeps the buffer busy for a while
  always @(posedge REF_CLK) begin
    if (TX_LOAD === 1'b1) begin
      #1;
      TX_BUFFER_EMPTY_FLAG = 1'b0;
      repeat (20) @(posedge REF_CLK);
      #1;
      TX_BUFFER_EMPTY_FLAG = 1'b1;
    end
  end

  function automatic urx_byte_t rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // an unexpected result meets an unknown note and so always fails
  task automatic cmp(input logic [9:0] got);
    logic [9:0] exp;
    exp = (notes.size() > 0) ? notes.pop_front() : 10'hXXX;
    chk({6'h00, got}, {6'h00, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic rx_char(input urx_byte_t dv, input logic pv, input logic stp,
      input logic pe, input bit push);
    urx_byte_t m;
    logic fe;
    m = dv & (8'hFF >> (2'h3 - CHAR_LEN));
    fe = !stp && !(m == 8'h00 && !(PARITY_EN && pv));
    if (push) notes.push_back({fe, pe, m});
    urx_line_model_i.send_char(dv, int'(CHAR_LEN) + 5, PARITY_EN, pv, stp,
      CLOCK_FACTOR == 2'h0);
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 3000 && notes.size() > 0; k++) @(posedge REF_CLK);
    if (notes.size() > 0) begin
      miscompares++;
      summarize();
    end
    step(4);
  endtask

  // watcher: takes the oldest note whenever a character shows up
  always @(posedge REF_CLK) begin
    if (TX_LOAD === 1'b1) begin
      cmp({2'b00, TX_DATA});
    end else if (RT_STATUS[0] === 1'b1 && !REMOTE_LOOP && !hold_reads) begin
      cmp({RT_STATUS[`URX_RT_FRAMING], RT_STATUS[`URX_RT_PARITY], RX_DATA});
      chk(COMBINED_IRQ_N, !(RT_MASK[0] | (RT_MASK[7] & RT_STATUS[7])));
      #1;
      RHR_READ = 1'b1;
      @(posedge REF_CLK);
      #1;
      RHR_READ = 1'b0;
    end
  end

  initial begin
    repeat (100000) @(posedge REF_CLK);
    miscompares++;
    summarize();
  end

  initial begin
    {RSTN, MASTER_RESET_PIN, POWER_DOWN_PIN, TX_CLOCK_PIN, DSR_N} = 5'h00;
    {DCD_N, CTS_N, RX_ENABLE_BIT, CARRIER_AUTO_EN, PARITY_EN} = 5'h18;
    {CHAR_LEN, PARITY_MODE, CLOCK_FACTOR, RX_CLOCK_INTERNAL} = 7'h63;
    {LOCAL_LOOP, REMOTE_LOOP, DTR_CMD, RTS_CMD, RT_STATUS_READ} = 5'h06;
    {MODEM_STATUS_READ, CPU_TX_WRITE, hold_reads} = 3'h0;
    RT_MASK = 8'h81;
    MODEM_MASK = 8'h08;
    CPU_TX_DATA = 8'h00;
    step(6);
    RSTN = 1'b1;
    pulse(MASTER_RESET_PIN);
    chk({RX_DATA, RT_STATUS}, 16'h0002);
    chk({MODEM_STATUS, 7'h00, COMBINED_IRQ_N}, 16'h0001);
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 0);
    RX_ENABLE_BIT = 1'b1;
    CARRIER_AUTO_EN = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 0);
    DCD_N = 1'b0;
    POWER_DOWN_PIN = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 0);
    POWER_DOWN_PIN = 1'b0;
    for (i = 0; i < 4; i++) begin
      CHAR_LEN = 2'(i);
      rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    end
    drain();
    chk({RT_STATUS[0], COMBINED_IRQ_N}, 16'h0001);
    RT_MASK = 8'h80;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    RT_MASK = 8'h81;
    PARITY_EN = 1'b1;
    for (pm = 0; pm < 4; pm++) begin
      for (bad = 0; bad < 2; bad++) begin
        PARITY_MODE = 2'(pm);
        d = rnd();
        p = (PARITY_MODE == `URX_PAR_ODD) ? ~^d : (PARITY_MODE == `URX_PAR_EVEN) ? ^d :
          (PARITY_MODE == `URX_PAR_MARK);
        rx_char(d, p[0] ^ bad[0], 1'b1, bad[0], 1);
      end
    end
    PARITY_EN = 1'b0;
    rx_char(rnd() | 8'h01, 1'b0, 1'b0, 1'b0, 1);
    urx_line_model_i.level(1'b1, 32);
    urx_line_model_i.level(1'b0, 8);
    urx_line_model_i.level(1'b1, 32);
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    rx_char(8'h00, 1'b0, 1'b0, 1'b0, 1);
    urx_line_model_i.level(1'b0, 64);
    chk({8'h00, MODEM_STATUS}, 16'h0088);
    chk({RT_STATUS[`URX_RT_DATA_SET_CHANGE_FLAG], COMBINED_IRQ_N}, 16'h0002);
    urx_line_model_i.level(1'b1, 8);
    urx_line_model_i.level(1'b0, 32);
    chk(MODEM_STATUS[`URX_MS_BRK], 1'b1);
    urx_line_model_i.level(1'b1, 64);
    chk(MODEM_STATUS[`URX_MS_BRK], 1'b0);
    MODEM_MASK = 8'h00;
    step(1);
    chk({RT_STATUS[`URX_RT_DATA_SET_CHANGE_FLAG], COMBINED_IRQ_N}, 16'h0001);
    MODEM_MASK = 8'h08;
    pulse(MODEM_STATUS_READ);
    step(1);
    chk(MODEM_STATUS[`URX_MS_BRK_CHG], 1'b0);
    drain();
    CLOCK_FACTOR = 2'h0;
    RX_CLOCK_INTERNAL = 1'b0;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    CLOCK_FACTOR = 2'h2;
    RX_CLOCK_INTERNAL = 1'b1;
    fast_tick = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    fast_tick = 1'b0;
    CLOCK_FACTOR = 2'h1;
    RX_CLOCK_INTERNAL = 1'b1;
    hold_reads = 1'b1;
    for (i = 0; i < 34; i++) rx_char(rnd(), 1'b0, 1'b1, 1'b0, i < 33);
    chk(RT_STATUS[`URX_RT_OVERRUN], 1'b1);
    hold_reads = 1'b0;
    drain();
    pulse(RT_STATUS_READ);
    step(1);
    chk(RT_STATUS[`URX_RT_OVERRUN], 1'b0);
    RX_ENABLE_BIT = 1'b0;
    {LOCAL_LOOP, DCD_N, CTS_N} = 3'h7;
    step(1);
    chk({TXD, DTR_N, RTS_N, CTS_N_INT, DSR_ACTIVE}, 16'h001C);
    RX_ENABLE_BIT = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    LOCAL_LOOP = 1'b0;
    step(1);
    chk({TXD, DTR_N, RTS_N, CTS_N_INT, DSR_ACTIVE}, 16'h0013);
    DCD_N = 1'b0;
    hold_reads = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    step(8);
    RX_ENABLE_BIT = 1'b0;
    TX_CLOCK_PIN = 1'b1;
    REMOTE_LOOP = 1'b1;
    step(1);
    chk({TX_FORCE_EN, TX_CLOCK_OUT}, {15'h0001, RX_CLOCK_PIN});
    RX_ENABLE_BIT = 1'b1;
    rx_char(rnd(), 1'b0, 1'b1, 1'b0, 1);
    drain();
    CPU_TX_DATA = rnd();
    pulse(CPU_TX_WRITE);
    step(8);
    REMOTE_LOOP = 1'b0;
    hold_reads = 1'b0;
    step(4);
    summarize();
  end
endmodule
`default_nettype wire

//--- verilog/urx_fifo.sv
// first-in first-out buffer with valid/ready on both sides.
// assumes one clock; flush empties it in one cycle.
`timescale 1ns/100ps
`default_nettype none
module urx_fifo
  import urx_pkg::*;
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  always_ff @(posedge clk) begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

//--- verilog/urx_receiver.sv
// receive side of an asynchronous serial port with break detection and
// local/remote loopback steering. assumes all inputs synchronous to REF_CLK
// and an external transmitter that consumes TX_LOAD/TX_DATA.
`timescale 1ns/100ps
`default_nettype none
`include "urx_defines.svh"
module urx_receiver
  import urx_pkg::*;
#(
  parameter int FIFO_DEPTH = `URX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic MASTER_RESET_PIN,
  input wire logic POWER_DOWN_PIN,
  // line side inputs
  input wire logic RXD,
  input wire logic RX_CLOCK_PIN,
  input wire logic TX_CLOCK_PIN,
  input wire logic DCD_N,
  input wire logic CTS_N,
  input wire logic DSR_N,
  // line side outputs
  output logic TXD,
  output logic DTR_N,
  output logic RTS_N,
  // configuration
  input wire logic RX_ENABLE_BIT,
  input wire logic CARRIER_AUTO_EN,
  input wire logic [1:0] CHAR_LEN,
  input wire logic PARITY_EN,
  input wire logic [1:0] PARITY_MODE,
  input wire logic [1:0] CLOCK_FACTOR,
  input wire logic RX_CLOCK_INTERNAL,
  input wire logic BAUD_TICK,
  input wire logic LOCAL_LOOP,
  input wire logic REMOTE_LOOP,
  input wire logic DTR_CMD,
  input wire logic RTS_CMD,
  input wire logic [7:0] RT_MASK,
  input wire logic [7:0] MODEM_MASK,
  // cpu side
  input wire logic RHR_READ,
  input wire logic RT_STATUS_READ,
  input wire logic MODEM_STATUS_READ,
  output urx_byte_t RX_DATA,
  output logic [7:0] RT_STATUS,
  output logic [7:0] MODEM_STATUS,
  output logic COMBINED_IRQ_N,
  // transmitter side
  input wire logic TX_SERIAL,
  input wire logic TX_BUFFER_EMPTY_FLAG,
  input wire logic CPU_TX_WRITE,
  input wire urx_byte_t CPU_TX_DATA,
  output logic TX_LOAD,
  output urx_byte_t TX_DATA,
  output logic TX_FORCE_EN,
  output logic TX_CLOCK_OUT,
  output logic CTS_N_INT,
  output logic DSR_ACTIVE
);
  urx_state_e state_reg, state_next;
  logic [6:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  urx_byte_t shift_reg, shift_next;
  logic par_reg, par_next;
  logic rx_prev_reg;
  logic clk_prev_reg;
  urx_byte_t hold_reg;
  logic [2:0] hold_err_reg;
  logic rx_ready_reg, rx_ready_next;
  logic overrun_reg, overrun_next;
  logic brk_reg, brk_next;
  logic brk_chg_reg, brk_chg_next;
  logic done;
  logic [`URX_ENTRY_W-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;

  // loopback steering
  wire rxs = LOCAL_LOOP ? TX_SERIAL : RXD;
  wire rx_clk_lvl = LOCAL_LOOP ? TX_CLOCK_PIN : RX_CLOCK_PIN;
  wire dcd_n_eff = LOCAL_LOOP ? ~DTR_CMD : DCD_N;
  assign CTS_N_INT = LOCAL_LOOP ? ~RTS_CMD : CTS_N;
  assign DSR_ACTIVE = LOCAL_LOOP ? 1'b0 : ~DSR_N;
  assign TXD = LOCAL_LOOP ? 1'b1 : TX_SERIAL;
  assign DTR_N = LOCAL_LOOP ? 1'b1 : ~DTR_CMD;
  assign RTS_N = LOCAL_LOOP ? 1'b1 : ~RTS_CMD;
  assign TX_CLOCK_OUT = REMOTE_LOOP ? RX_CLOCK_PIN : TX_CLOCK_PIN;
  assign TX_FORCE_EN = REMOTE_LOOP;

  // power down stops the receiver except in break wait, which runs on; a half-built character is lost
  wire rx_on = RX_ENABLE_BIT & ~(CARRIER_AUTO_EN & dcd_n_eff) & ~POWER_DOWN_PIN;
  wire clk_fall = clk_prev_reg & ~rx_clk_lvl;
  wire tick = RX_CLOCK_INTERNAL ? BAUD_TICK : clk_fall;
  wire is_1x = (CLOCK_FACTOR == 2'h0);
  wire [6:0] bit_len = (CLOCK_FACTOR == 2'h1) ? `URX_BIT_16X :
                       (CLOCK_FACTOR == 2'h2) ? `URX_BIT_32X :
                       (CLOCK_FACTOR == 2'h3) ? `URX_BIT_64X : `URX_BIT_1X;
  wire [6:0] half_len = is_1x ? `URX_BIT_1X : {1'b0, bit_len[6:1]};
  wire centre = tick & (cnt_reg == 7'h01);
  wire [2:0] last_bit = 3'h4 + {1'b0, CHAR_LEN};
  wire start_edge = tick & rx_prev_reg & ~rxs;

  // parity and break decode over the assembled character
  wire data_par = ^shift_reg;
  wire exp_par = (PARITY_MODE == `URX_PAR_ODD) ? ~data_par :
                 (PARITY_MODE == `URX_PAR_EVEN) ? data_par :
                 (PARITY_MODE == `URX_PAR_MARK) ? 1'b1 : 1'b0;
  wire par_err = PARITY_EN & (par_reg != exp_par);
  wire brk_char = (shift_reg == 8'h00) & (~PARITY_EN | ~par_reg) & ~rxs;
  wire frm_err = ~rxs & ~brk_char;
  wire brk_end = (state_reg == URX_BRK_WAIT) & centre & rxs;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    par_next = par_reg;
    done = 1'b0;
    unique case (state_reg)
      URX_IDLE: begin
        if (rx_on && start_edge) begin
          cnt_next = half_len;
          state_next = is_1x ? URX_DATA : URX_START;
          bit_next = 3'h0;
          shift_next = `URX_DATA_RST;
        end
      end
      URX_START: begin
        if (centre) begin
          cnt_next = bit_len;
          state_next = rxs ? URX_IDLE : URX_DATA;
        end else if (tick)
          cnt_next = cnt_reg - 7'h01;
      end
      URX_DATA: begin
        if (centre) begin
          cnt_next = bit_len;
          shift_next[bit_reg] = rxs;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == last_bit)
            state_next = PARITY_EN ? URX_PARITY : URX_STOP;
        end else if (tick)
          cnt_next = cnt_reg - 7'h01;
      end
      URX_PARITY: begin
        if (centre) begin
          cnt_next = bit_len;
          par_next = rxs;
          state_next = URX_STOP;
        end else if (tick)
          cnt_next = cnt_reg - 7'h01;
      end
      URX_STOP: begin
        // only the first stop bit is looked at
        if (centre) begin
          done = 1'b1;
          cnt_next = half_len;
          state_next = brk_char ? URX_BRK_WAIT : URX_IDLE;
        end else if (tick)
          cnt_next = cnt_reg - 7'h01;
      end
      URX_BRK_WAIT: begin
        // any low tick restarts the half-bit high window
        if (tick && !rxs)
          cnt_next = half_len;
        else if (centre)
          state_next = URX_IDLE;
        else if (tick)
          cnt_next = cnt_reg - 7'h01;
      end
    endcase
    if (!rx_on && state_reg != URX_BRK_WAIT)
      state_next = URX_IDLE;
  end

  // character buffer between assembly and holding register
  wire [`URX_ENTRY_W-1:0] fifo_in = {brk_char, frm_err, par_err, shift_reg};
  wire fifo_pop = fifo_valid & ~rx_ready_reg;
  wire seq_copy = REMOTE_LOOP & rx_ready_reg & TX_BUFFER_EMPTY_FLAG;
  wire cpu_clear = RHR_READ & ~REMOTE_LOOP;
  urx_fifo #(
    .WIDTH(`URX_ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .flush(MASTER_RESET_PIN),
    .in_valid(done),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(~rx_ready_reg),
    .out_data(fifo_out)
  );

  // flags: a set in the same cycle as a clear wins
  assign rx_ready_next = fifo_pop | (rx_ready_reg & ~cpu_clear & ~seq_copy);
  assign overrun_next = (done & ~fifo_in_ready) | (overrun_reg & ~RT_STATUS_READ);
  assign brk_next = (done & brk_char) | (brk_reg & ~brk_end);
  assign brk_chg_next = (done & brk_char) | brk_end | (brk_chg_reg & ~MODEM_STATUS_READ);

  // cpu transmit writes are dropped while the sequencer owns the path
  assign TX_LOAD = REMOTE_LOOP ? seq_copy : CPU_TX_WRITE;
  assign TX_DATA = REMOTE_LOOP ? hold_reg : CPU_TX_DATA;

  // status assembly and interrupt gating, masks may change at any time
  wire data_set_change_flag = brk_chg_reg & MODEM_MASK[`URX_MS_BRK_CHG];
  assign RT_STATUS = {data_set_change_flag, 2'b00, overrun_reg, hold_err_reg[1], hold_err_reg[0],
                      TX_BUFFER_EMPTY_FLAG, rx_ready_reg};
  assign MODEM_STATUS = {brk_reg, 3'b000, brk_chg_reg, 3'b000};
  assign COMBINED_IRQ_N = ~|(RT_STATUS & RT_MASK);
  assign RX_DATA = hold_reg;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= URX_IDLE;
      cnt_reg <= 7'h00;
      bit_reg <= 3'h0;
      shift_reg <= `URX_DATA_RST;
      par_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b0;
    end else if (MASTER_RESET_PIN) begin
      state_reg <= URX_IDLE;
      cnt_reg <= 7'h00;
      bit_reg <= 3'h0;
      shift_reg <= `URX_DATA_RST;
      par_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      par_reg <= par_next;
      clk_prev_reg <= rx_clk_lvl;
      if (tick)
        rx_prev_reg <= rxs;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hold_reg <= `URX_DATA_RST;
      hold_err_reg <= 3'h0;
      rx_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      brk_reg <= 1'b0;
      brk_chg_reg <= 1'b0;
    end else if (MASTER_RESET_PIN) begin
      hold_reg <= `URX_DATA_RST;
      hold_err_reg <= 3'h0;
      rx_ready_reg <= 1'b0;
      overrun_reg <= 1'b0;
      brk_reg <= 1'b0;
      brk_chg_reg <= 1'b0;
    end else begin
      if (fifo_pop) begin
        hold_reg <= fifo_out[7:0];
        hold_err_reg <= fifo_out[10:8];
      end
      rx_ready_reg <= rx_ready_next;
      overrun_reg <= overrun_next;
      brk_reg <= brk_next;
      brk_chg_reg <= brk_chg_next;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || MASTER_RESET_PIN);

  enable_idle_a: assert property (
    !rx_on && state_reg != URX_BRK_WAIT |=> state_reg == URX_IDLE)
    else $error("receiver left idle while disabled");
  valid_start_a: assert property (
    state_reg == URX_START && centre && !rxs |=> state_reg == URX_DATA && cnt_reg == bit_len)
    else $error("valid start not accepted");
  false_start_a: assert property (
    state_reg == URX_START && centre && rxs |=> state_reg == URX_IDLE)
    else $error("false start not discarded");
  ready_irq_a: assert property (
    fifo_pop && RT_MASK[`URX_RT_RX_READY] |=> rx_ready_reg && !COMBINED_IRQ_N)
    else $error("ready or interrupt missing after transfer");
  read_clear_a: assert property (
    rx_ready_reg && cpu_clear |=> !rx_ready_reg)
    else $error("holding read did not clear ready");
  break_flags_a: assert property (
    done && brk_char |=> brk_reg && brk_chg_reg && MODEM_STATUS[`URX_MS_BRK])
    else $error("break flags not set");
  break_end_a: assert property (
    brk_reg && !$past(brk_end) && !$past(done) |-> $past(brk_reg))
    else $error("break flag rose without a break character");
  data_set_change_flag_irq_a: assert property (
    brk_chg_reg && MODEM_MASK[`URX_MS_BRK_CHG] && RT_MASK[`URX_RT_DATA_SET_CHANGE_FLAG] |-> !COMBINED_IRQ_N)
    else $error("data set change did not raise interrupt");
  short_zero_a: assert property (
    $rose(rx_ready_reg) && CHAR_LEN == 2'h0 && $stable(CHAR_LEN) [*1] |-> RX_DATA[7:5] == 3'h0)
    else $error("unused data bits not zero");
  local_pins_a: assert property (
    LOCAL_LOOP |-> TXD && DTR_N && RTS_N && !DSR_ACTIVE)
    else $error("local loopback line outputs wrong");
  remote_copy_a: assert property (
    seq_copy |-> TX_LOAD && TX_DATA == hold_reg ##1 !rx_ready_reg || fifo_pop)
    else $error("remote copy did not complete");
  cpu_block_a: assert property (
    REMOTE_LOOP && CPU_TX_WRITE && !seq_copy |-> !TX_LOAD)
    else $error("cpu transmit write passed in remote loopback");
  overrun_set_a: assert property (
    done && !fifo_in_ready |=> overrun_reg [*1] ##0 RT_STATUS[`URX_RT_OVERRUN])
    else $error("overrun not flagged");

  false_start_c: cover property (state_reg == URX_START && centre && rxs);
  break_seen_c: cover property (brk_end);
  remote_copy_c: cover property (seq_copy);
  overrun_c: cover property (done && !fifo_in_ready);
endmodule
`default_nettype wire
